// ### rtl/debug_port_select_logic.sv
// debug port selection and debug register map reached over the jtag scan path
// assumes all pins are asynchronous to clk and that tck runs far below clk
// Contract
// - sixteen debug registers, five-bit scan address
// - six-bit control forces debug, disables interrupts
// - two watch units with value and mask registers
// - comms control at 00100, data at 00101
// - debug mode ties jtag pins to debug logic
// - pull-up on the returned clock pin
// - returned clock driver off until wakeup ends
// - primary pins ignore pin multiplexer once jtag
// - primary jtag and trace need both ones
// - any low sample disables primary until reset
// - secondary jtag follows software pin select
// - trace off whenever secondary jtag is used
// - select low leaves primary pins to multiplexer
`timescale 1ns/1ps
module debug_port_select_logic (
	input  wire logic                clk,              // 200 MHz system clock
	input  wire logic                rst_n,            // async reset, low active
	input  wire logic                wakeup_done,      // internal reset released
	input  wire logic                debug_select_pin, // debug select pin
	input  wire logic                returned_test_clock_in,          // returned clock pin level
	output logic                     returned_test_clock_out,         // returned clock drive value
	output logic                     returned_test_clock_oe,          // returned clock drive enable
	output logic                     returned_test_clock_pullup_en,   // pull-up on returned clock
	input  wire dbg_pkg::jtag_pins_t primary_jtag,     // jtag on primary debug pins
	output logic                     primary_tdo,      // tdo value, primary pins
	output logic                     primary_tdo_oe,   // tdo enable, primary pins
	input  wire dbg_pkg::jtag_pins_t secondary_jtag,   // jtag on secondary pins
	output logic                     secondary_tdo,    // tdo value, secondary pins
	output logic                     secondary_tdo_oe, // tdo enable, secondary pins
	input  wire logic                pin_function_select_reg1_jtag, // software jtag select
	output logic                     primary_pins_pinmux, // primary pins follow multiplexer
	output logic                     trace_macrocell_en,  // trace port enabled
	output logic                     force_debug,      // force core into debug state
	output logic                     irq_disable,      // interrupts disabled
	output logic                     secondary_active  // secondary pins carry jtag
);

	// ---------------- input synchronisers ----------------
	localparam int SYNC_W = 7;                         // synchronised signal count

	logic [SYNC_W-1:0] sync_raw;                       // asynchronous inputs
	logic [SYNC_W-1:0] sync_meta;                      // first stage only
	logic [SYNC_W-1:0] sync_out;                       // second stage, safe to use
	logic              primary_active;                 // primary pins own jtag
	dbg_pkg::jtag_pins_t jtag_src;                     // selected pin set
	logic              wake_s;                         // synced wakeup
	logic              debug_select_pin_s;                       // synced select pin
	logic              returned_test_clock_s;                         // synced returned clock
	dbg_pkg::jtag_pins_t jtag_s;                       // synced jtag pins

	// pick the pin set that owns jtag; select is static after capture
	always_comb begin
		if (primary_active) begin
			jtag_src = primary_jtag;
		end else begin
			jtag_src = secondary_jtag;
		end
	end

	assign sync_raw = {wakeup_done, debug_select_pin, returned_test_clock_in, jtag_src};

	// two flip-flops for each pin level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta <= '0;
			sync_out  <= '0;
		end else begin
			sync_meta <= sync_raw;
			sync_out  <= sync_meta;
		end
	end

	assign wake_s   = sync_out[6];
	assign debug_select_pin_s = sync_out[5];
	assign returned_test_clock_s   = sync_out[4];
	assign jtag_s   = sync_out[3:0];

	// ---------------- port selection ----------------
	dbg_pkg::port_sel_t sel;                           // decision taken at wakeup

	// sample select pin and returned clock once, at internal reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel <= '0;
		end else if (wake_s && !sel.captured) begin
			sel.captured    <= 1'b1;
			sel.debug_select_pin_seen <= debug_select_pin_s;
			sel.returned_test_clock_seen   <= returned_test_clock_s;
			sel.primary     <= debug_select_pin_s & returned_test_clock_s;
		end
	end

	assign primary_active   = sel.primary;
	assign secondary_active = sel.captured & ~sel.primary
		& pin_function_select_reg1_jtag;

	// primary pins go to the multiplexer unless they became jtag
	assign primary_pins_pinmux = ~sel.primary;
	// trace shares the secondary pins, so only primary mode enables it
	assign trace_macrocell_en  = sel.primary;
	assign returned_test_clock_pullup_en      = 1'b1;

	// returned clock echoes synced tck once the wakeup interval is over
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			returned_test_clock_out <= 1'b0;
			returned_test_clock_oe  <= 1'b0;
		end else begin
			returned_test_clock_oe  <= sel.captured;
			returned_test_clock_out <= sel.captured & jtag_s.tck;
		end
	end

	// ---------------- tck edge detection ----------------
	logic link_live;                                   // some pin set owns jtag
	logic tck_d;                                       // delayed synced tck
	logic tck_rise;                                    // tck rising edge seen
	logic tck_fall;                                    // tck falling edge seen

	assign link_live = primary_active | secondary_active;

	// remember last tck level for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_d <= 1'b0;
		end else begin
			tck_d <= jtag_s.tck;
		end
	end

	assign tck_rise = jtag_s.tck & ~tck_d;
	assign tck_fall = ~jtag_s.tck & tck_d;

	// ---------------- tap controller ----------------
	dbg_pkg::tap_state_t tap;                          // current tap state
	dbg_pkg::tap_state_t next_tap;                     // state after this tck

	// standard tap transitions on tms
	always_comb begin
		next_tap = tap;
		case (tap)
			dbg_pkg::TAP_RESET:  next_tap = jtag_s.tms ? dbg_pkg::TAP_RESET  : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_IDLE:   next_tap = jtag_s.tms ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_DR: next_tap = jtag_s.tms ? dbg_pkg::TAP_SEL_IR : dbg_pkg::TAP_CAP_DR;
			dbg_pkg::TAP_CAP_DR: next_tap = jtag_s.tms ? dbg_pkg::TAP_EX1_DR : dbg_pkg::TAP_SH_DR;
			dbg_pkg::TAP_SH_DR:  next_tap = jtag_s.tms ? dbg_pkg::TAP_EX1_DR : dbg_pkg::TAP_SH_DR;
			dbg_pkg::TAP_EX1_DR: next_tap = jtag_s.tms ? dbg_pkg::TAP_UPD_DR : dbg_pkg::TAP_PA_DR;
			dbg_pkg::TAP_PA_DR:  next_tap = jtag_s.tms ? dbg_pkg::TAP_EX2_DR : dbg_pkg::TAP_PA_DR;
			dbg_pkg::TAP_EX2_DR: next_tap = jtag_s.tms ? dbg_pkg::TAP_UPD_DR : dbg_pkg::TAP_SH_DR;
			dbg_pkg::TAP_UPD_DR: next_tap = jtag_s.tms ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_IR: next_tap = jtag_s.tms ? dbg_pkg::TAP_RESET  : dbg_pkg::TAP_CAP_IR;
			dbg_pkg::TAP_CAP_IR: next_tap = jtag_s.tms ? dbg_pkg::TAP_EX1_IR : dbg_pkg::TAP_SH_IR;
			dbg_pkg::TAP_SH_IR:  next_tap = jtag_s.tms ? dbg_pkg::TAP_EX1_IR : dbg_pkg::TAP_SH_IR;
			dbg_pkg::TAP_EX1_IR: next_tap = jtag_s.tms ? dbg_pkg::TAP_UPD_IR : dbg_pkg::TAP_PA_IR;
			dbg_pkg::TAP_PA_IR:  next_tap = jtag_s.tms ? dbg_pkg::TAP_EX2_IR : dbg_pkg::TAP_PA_IR;
			dbg_pkg::TAP_EX2_IR: next_tap = jtag_s.tms ? dbg_pkg::TAP_UPD_IR : dbg_pkg::TAP_SH_IR;
			dbg_pkg::TAP_UPD_IR: next_tap = jtag_s.tms ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
			default:             next_tap = dbg_pkg::TAP_RESET;
		endcase
	end

	// advance on tck rise; held in reset when no pin set owns jtag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap <= dbg_pkg::TAP_RESET;
		end else if (!link_live || !jtag_s.trst_n) begin
			tap <= dbg_pkg::TAP_RESET;
		end else if (tck_rise) begin
			tap <= next_tap;
		end
	end

	// ---------------- debug scan chain ----------------
	logic [dbg_pkg::CHAIN_W-1:0] chain;                // data, address, write flag
	logic [dbg_pkg::ADDR_W-1:0]  cur_addr;             // address of last update
	logic [dbg_pkg::DATA_W-1:0]  store_rdata;          // store read word
	logic [dbg_pkg::DATA_W-1:0]  read_word;            // value captured for readout
	logic [dbg_pkg::W_DEBUG_CONTROL-1:0] debug_control; // control register
	logic [dbg_pkg::W_DEBUG_STATUS-1:0]  debug_status;  // status view
	logic [dbg_pkg::ADDR_W-1:0]  upd_addr;             // address field of chain
	logic [dbg_pkg::DATA_W-1:0]  upd_data;             // data field of chain
	logic                        upd_fire;             // update-dr on this tck
	logic                        upd_write;            // write into a mapped register

	assign upd_addr  = chain[dbg_pkg::ADDR_HI:dbg_pkg::ADDR_LO];
	assign upd_data  = chain[dbg_pkg::DATA_W-1:0];
	assign upd_fire  = tck_rise && link_live && jtag_s.trst_n && tap == dbg_pkg::TAP_UPD_DR;
	assign upd_write = upd_fire && chain[dbg_pkg::WR_BIT]
		&& dbg_pkg::reg_hit(upd_addr);

	// status shows the block's own selection state
	always_comb begin
		debug_status = '0;
		debug_status[dbg_pkg::STAT_PRIMARY_BIT]   = sel.primary;
		debug_status[dbg_pkg::STAT_SECONDARY_BIT] = secondary_active;
		debug_status[dbg_pkg::STAT_TRACE_BIT]     = trace_macrocell_en;
		debug_status[dbg_pkg::STAT_DEBUG_SELECT_PIN_BIT]    = sel.debug_select_pin_seen;
		debug_status[dbg_pkg::STAT_RETURNED_TEST_CLOCK_BIT]      = sel.returned_test_clock_seen;
	end

	// readout word for the address held from the last update
	always_comb begin
		if (!dbg_pkg::reg_hit(cur_addr)) begin
			read_word = dbg_pkg::ZERO_WORD;
		end else if (cur_addr == dbg_pkg::ADDR_DEBUG_CONTROL) begin
			read_word = {26'h0000000, debug_control};
		end else if (cur_addr == dbg_pkg::ADDR_DEBUG_STATUS) begin
			read_word = {27'h0000000, debug_status};
		end else begin
			read_word = store_rdata & dbg_pkg::reg_mask(cur_addr);
		end
	end

	// capture loads the readout, shift moves tdi in at the top
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain <= '0;
		end else if (tck_rise && tap == dbg_pkg::TAP_CAP_DR) begin
			chain <= {1'b0, cur_addr, read_word};
		end else if (tck_rise && tap == dbg_pkg::TAP_SH_DR) begin
			chain <= {jtag_s.tdi, chain[dbg_pkg::CHAIN_W-1:1]};
		end
	end

	// update latches the five-bit address for the next readout
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_addr <= dbg_pkg::ADDR_DEBUG_CONTROL;
		end else if (upd_fire) begin
			cur_addr <= upd_addr;
		end
	end

	// control register; drives the core's debug request and irq gate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debug_control <= dbg_pkg::RST_DEBUG_CONTROL;
		end else if (upd_write && upd_addr == dbg_pkg::ADDR_DEBUG_CONTROL) begin
			debug_control <= upd_data[dbg_pkg::W_DEBUG_CONTROL-1:0];
		end
	end

	assign force_debug = debug_control[dbg_pkg::CTRL_FORCE_BIT];
	assign irq_disable = debug_control[dbg_pkg::CTRL_INTDIS_BIT];

	logic store_wr;                                    // write to comms or watch word

	// status is read-only; control lives in its own flops
	assign store_wr = upd_write
		&& upd_addr != dbg_pkg::ADDR_DEBUG_CONTROL
		&& upd_addr != dbg_pkg::ADDR_DEBUG_STATUS;

	// comms and watch unit words, trimmed to their widths on write
	dbg_reg_store #(
		.WIDTH (dbg_pkg::DATA_W),
		.DEPTH (dbg_pkg::DEPTH),
		.AW    (dbg_pkg::ADDR_W)
	) u_store (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (store_wr),
		.wr_addr (upd_addr),
		.wr_data (upd_data & dbg_pkg::reg_mask(upd_addr)),
		.rd_addr (cur_addr),
		.rd_data (store_rdata)
	);

	// ---------------- tdo ----------------
	logic shifting;                                    // tap in a shift state

	assign shifting = tap == dbg_pkg::TAP_SH_DR || tap == dbg_pkg::TAP_SH_IR;

	// tdo changes on the falling tck edge, only on the owning pin set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_tdo      <= 1'b0;
			primary_tdo_oe   <= 1'b0;
			secondary_tdo    <= 1'b0;
			secondary_tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			primary_tdo      <= primary_active & (tap == dbg_pkg::TAP_SH_DR) & chain[0];
			primary_tdo_oe   <= primary_active & shifting;
			secondary_tdo    <= secondary_active & (tap == dbg_pkg::TAP_SH_DR) & chain[0];
			secondary_tdo_oe <= secondary_active & shifting;
		end else if (!link_live) begin
			primary_tdo_oe   <= 1'b0;
			secondary_tdo_oe <= 1'b0;
		end
	end

endmodule // debug_port_select_logic

// ### rtl/dbg_pkg.sv
// debug port selection package: register map, field layout, pin and state types
// assumes a single 200 MHz system clock domain for every user of these names
package dbg_pkg;

	// scan chain layout: data word, register address, write flag
	localparam int ADDR_W  = 5;                        // register address width
	localparam int DATA_W  = 32;                       // register data width
	localparam int CHAIN_W = DATA_W + ADDR_W + 1;      // whole debug chain length
	localparam int ADDR_LO = DATA_W;                   // address field low bit
	localparam int ADDR_HI = DATA_W + ADDR_W - 1;      // address field high bit
	localparam int WR_BIT  = CHAIN_W - 1;              // write flag position
	localparam int DEPTH   = 32;                       // full address space of the store

	// register addresses
	localparam logic [4:0] ADDR_DEBUG_CONTROL    = 5'h00; // force debug, irq disable
	localparam logic [4:0] ADDR_DEBUG_STATUS     = 5'h01; // read-only state
	localparam logic [4:0] ADDR_COMMS_CONTROL    = 5'h04; // comms channel control
	localparam logic [4:0] ADDR_COMMS_DATA       = 5'h05; // comms channel data
	localparam logic [4:0] ADDR_M0_ADDR_VALUE    = 5'h08; // unit 0 address value
	localparam logic [4:0] ADDR_M0_ADDR_MASK     = 5'h09; // unit 0 address mask
	localparam logic [4:0] ADDR_M0_DATA_VALUE    = 5'h0A; // unit 0 data value
	localparam logic [4:0] ADDR_M0_DATA_MASK     = 5'h0B; // unit 0 data mask
	localparam logic [4:0] ADDR_M0_CTRL_VALUE    = 5'h0C; // unit 0 control value
	localparam logic [4:0] ADDR_M0_CTRL_MASK     = 5'h0D; // unit 0 control mask
	localparam logic [4:0] ADDR_M1_ADDR_VALUE    = 5'h10; // unit 1 address value
	localparam logic [4:0] ADDR_M1_ADDR_MASK     = 5'h11; // unit 1 address mask
	localparam logic [4:0] ADDR_M1_DATA_VALUE    = 5'h12; // unit 1 data value
	localparam logic [4:0] ADDR_M1_DATA_MASK     = 5'h13; // unit 1 data mask
	localparam logic [4:0] ADDR_M1_CTRL_VALUE    = 5'h14; // unit 1 control value
	localparam logic [4:0] ADDR_M1_CTRL_MASK     = 5'h15; // unit 1 control mask

	// register widths
	localparam int W_DEBUG_CONTROL = 6;                // control bits
	localparam int W_DEBUG_STATUS  = 5;                // status bits
	localparam int W_CTRL_VALUE    = 9;                // watch control value
	localparam int W_CTRL_MASK     = 8;                // watch control mask

	// debug control fields
	localparam int CTRL_FORCE_BIT  = 0;                // force core into debug state
	localparam int CTRL_INTDIS_BIT = 2;                // disable interrupts

	// debug status fields
	localparam int STAT_PRIMARY_BIT   = 0;             // primary port owns jtag
	localparam int STAT_SECONDARY_BIT = 1;             // secondary pins own jtag
	localparam int STAT_TRACE_BIT     = 2;             // trace port enabled
	localparam int STAT_DEBUG_SELECT_PIN_BIT    = 3;             // select pin seen high
	localparam int STAT_RETURNED_TEST_CLOCK_BIT      = 4;             // returned clock seen high

	// reset values
	localparam logic [5:0]  RST_DEBUG_CONTROL = 6'h00; // control after reset
	localparam logic [31:0] ZERO_WORD         = 32'h00000000; // unmapped read value

	// jtag pin group from one pin set
	typedef struct packed {
		logic tck;                                     // test clock
		logic tms;                                     // mode select
		logic tdi;                                     // serial data in
		logic trst_n;                                  // test reset, low active
	} jtag_pins_t;

	// port selection decided at reset release
	typedef struct packed {
		logic captured;                                // pins have been sampled
		logic primary;                                 // primary jtag and trace on
		logic debug_select_pin_seen;                             // sampled select pin
		logic returned_test_clock_seen;                               // sampled returned clock
	} port_sel_t;

	// test access port controller states
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} tap_state_t;

	// true for the sixteen implemented addresses
	function automatic logic reg_hit(input logic [4:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == ADDR_DEBUG_CONTROL || addr == ADDR_DEBUG_STATUS) begin
			hit = 1'b1;
		end else if (addr == ADDR_COMMS_CONTROL || addr == ADDR_COMMS_DATA) begin
			hit = 1'b1;
		end else if (addr >= ADDR_M0_ADDR_VALUE && addr <= ADDR_M0_CTRL_MASK) begin
			hit = 1'b1;
		end else if (addr >= ADDR_M1_ADDR_VALUE && addr <= ADDR_M1_CTRL_MASK) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// mask of the bits a register really holds
	function automatic logic [31:0] reg_mask(input logic [4:0] addr);
		logic [31:0] m;
		m = '1;
		if (!reg_hit(addr)) begin
			m = ZERO_WORD;
		end else if (addr == ADDR_DEBUG_CONTROL) begin
			m = 32'((64'h1 << W_DEBUG_CONTROL) - 64'h1);
		end else if (addr == ADDR_DEBUG_STATUS) begin
			m = 32'((64'h1 << W_DEBUG_STATUS) - 64'h1);
		end else if (addr == ADDR_M0_CTRL_VALUE || addr == ADDR_M1_CTRL_VALUE) begin
			m = 32'((64'h1 << W_CTRL_VALUE) - 64'h1);
		end else if (addr == ADDR_M0_CTRL_MASK || addr == ADDR_M1_CTRL_MASK) begin
			m = 32'((64'h1 << W_CTRL_MASK) - 64'h1);
		end
		return m;
	endfunction

endpackage

// ### rtl/dbg_reg_store.sv
// small register store for the debug register words, registered read port
// assumes writes and reads come from logic on the same clock
`timescale 1ns/1ps
module dbg_reg_store #(
	parameter int WIDTH = 32,                          // word width
	parameter int DEPTH = 32,                          // number of words
	parameter int AW    = 5                            // address width
) (
	input  wire logic             clk,                 // system clock
	input  wire logic             rst_n,               // async reset, low active
	input  wire logic             wr_en,               // write strobe
	input  wire logic [AW-1:0]    wr_addr,             // write address
	input  wire logic [WIDTH-1:0] wr_data,             // write data
	input  wire logic [AW-1:0]    rd_addr,             // read address
	output logic      [WIDTH-1:0] rd_data              // read data, one cycle late
);

	logic [WIDTH-1:0] mem [DEPTH];                     // storage words

	// write port; contents are undefined until written
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read port from a register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule // dbg_reg_store

// ### test/debug_port_select_monitor.sv
// checker for the port selection outputs of the debug port block
// assumes one clock domain and sees only the block's top-level ports
`timescale 1ns/1ps
module debug_port_select_monitor (
	input wire logic clk,                           // system clock
	input wire logic rst_n,                         // async reset, low active
	input wire logic wakeup_done,                   // internal reset released
	input wire logic debug_select_pin,              // debug select pin
	input wire logic returned_test_clock_in,                       // returned clock pin level
	input wire logic returned_test_clock_oe,                       // returned clock drive enable
	input wire logic returned_test_clock_pullup_en,                // pull-up request
	input wire logic primary_tdo_oe,                // tdo enable, primary pins
	input wire logic secondary_tdo_oe,              // tdo enable, secondary pins
	input wire logic pin_function_select_reg1_jtag, // software jtag select
	input wire logic primary_pins_pinmux,           // primary pins follow multiplexer
	input wire logic trace_macrocell_en,            // trace port enabled
	input wire logic secondary_active               // secondary pins carry jtag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pull-up always requested
	chk_pullup_held: assert property (returned_test_clock_pullup_en) else $error("pull-up dropped");
	// driver stays off until wakeup has been seen
	chk_drive_wait: assert property (returned_test_clock_oe |-> $past(wakeup_done, 2))
		else $error("returned clock driven before wakeup");
	// trace and primary jtag only with both samples high
	chk_trace_cause: assert property ($rose(trace_macrocell_en) |->
		$past(debug_select_pin, 4) && $past(returned_test_clock_in, 4)) else $error("trace without both pins");
	// primary pins leave the multiplexer exactly when primary is selected
	chk_pinmux_pair: assert property (trace_macrocell_en == !primary_pins_pinmux)
		else $error("pin multiplexer and trace disagree");
	// selection changes only before the drive enable comes up
	chk_sel_frozen: assert property (!$stable(trace_macrocell_en) |-> !$past(returned_test_clock_oe))
		else $error("selection changed after capture");
	// trace and secondary jtag exclude each other
	chk_trace_excl: assert property (!(trace_macrocell_en && secondary_active))
		else $error("trace and secondary jtag together");
	// secondary jtag only on software request
	chk_sec_request: assert property (secondary_active |-> pin_function_select_reg1_jtag)
		else $error("secondary jtag without select bit");
	// non-owning pin sets never drive tdo, except the secondary set for one cycle after it stops owning jtag
	chk_prim_quiet: assert property (!trace_macrocell_en |-> !primary_tdo_oe)
		else $error("primary tdo driven while not selected");
	chk_sec_quiet: assert property (!secondary_active && !$past(secondary_active) |->
		!secondary_tdo_oe) else $error("secondary tdo driven while not selected");
	cov_primary: cover property ($rose(trace_macrocell_en));
	cov_secondary: cover property ($rose(secondary_active));
	cov_prim_shift: cover property (primary_tdo_oe);
	cov_sec_shift: cover property (secondary_tdo_oe);
endmodule // debug_port_select_monitor
bind debug_port_select_logic debug_port_select_monitor mon_inst (.clk(clk), .rst_n(rst_n),
	.wakeup_done(wakeup_done), .debug_select_pin(debug_select_pin), .returned_test_clock_in(returned_test_clock_in),
	.returned_test_clock_oe(returned_test_clock_oe), .returned_test_clock_pullup_en(returned_test_clock_pullup_en), .primary_tdo_oe(primary_tdo_oe),
	.secondary_tdo_oe(secondary_tdo_oe), .primary_pins_pinmux(primary_pins_pinmux),
	.pin_function_select_reg1_jtag(pin_function_select_reg1_jtag),
	.trace_macrocell_en(trace_macrocell_en), .secondary_active(secondary_active));

// ### test/jtag_probe.sv
// behavioural debug probe: drives tck, tms, tdi, trst_n and samples tdo
// assumes tdo is settled at each tck rise; tck stands low between scans
`timescale 1ns/1ps
module jtag_probe (
	output dbg_pkg::jtag_pins_t pins,   // probe pin group
	input  wire logic           tdo     // tdo as seen on the wire
);
	initial pins = 4'h1;                // tck low, trst_n high
	// one tck period of 125 ns, signals change after the fall
	task automatic step(input logic tms, input logic tdi, output logic seen);
		pins.tms = tms;
		pins.tdi = tdi;
		#31.25 pins.tck = 1'b1;
		seen = tdo;                     // sample on the rising edge
		#62.5 pins.tck = 1'b0;
		#31.25;
	endtask
	// five tms highs reach test reset, then settle in idle
	task automatic tap_reset();
		logic s;
		repeat (5) step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
	endtask
	// one data scan from idle back to idle, lsb first in and out
	task automatic scan(input logic [37:0] din, output logic [37:0] dout);
		logic s;
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
		step(1'b0, 1'b0, s);
		for (int i = 0; i < 38; i++) begin
			step(i == 37, din[i], dout[i]);
		end
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
	endtask
endmodule // jtag_probe

// ### test/debug_port_select_logic_tb.sv
// bench: resets the block in each pin mode and scans registers through the probe
// assumes the probe model and the checker bind are compiled alongside
`timescale 1ns/1ps
module debug_port_select_logic_tb;
	logic clk = 0, rst_n = 0, wake = 0, sel = 0, rt_low = 0, pinsel = 0, use_sec = 0;
	logic rt_out, rt_oe, pull, p_tdo, p_oe, s_tdo, s_oe, trace, pmux, frc, irq, sec;
	logic [37:0] so;                                   // scan result
	int n_fail = 0, n_compared = 0;
	wire dbg_pkg::jtag_pins_t pins;                    // probe pins
	wire dbg_pkg::jtag_pins_t pj = use_sec ? 4'h0 : pins; // primary set
	wire dbg_pkg::jtag_pins_t sj = use_sec ? pins : 4'h0; // secondary set
	wire rt_w = rt_oe ? rt_out : (rt_low ? 1'b0 : pull); // pull-up unless driven low
	wire tdo_w = use_sec ? (s_oe ? s_tdo : ~s_tdo) : (p_oe ? p_tdo : ~p_tdo);
	always #2.5 clk = ~clk;
	jtag_probe jtag_probe_inst (.pins(pins), .tdo(tdo_w));
	debug_port_select_logic debug_port_select_logic_inst (.clk(clk), .rst_n(rst_n),
		.wakeup_done(wake), .debug_select_pin(sel), .returned_test_clock_in(rt_w), .returned_test_clock_out(rt_out),
		.returned_test_clock_oe(rt_oe), .returned_test_clock_pullup_en(pull), .primary_jtag(pj), .primary_tdo(p_tdo),
		.primary_tdo_oe(p_oe), .secondary_jtag(sj), .secondary_tdo(s_tdo),
		.secondary_tdo_oe(s_oe), .pin_function_select_reg1_jtag(pinsel),
		.primary_pins_pinmux(pmux), .trace_macrocell_en(trace), .force_debug(frc),
		.irq_disable(irq), .secondary_active(sec));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// reset with pins held from before reset until after wakeup
	task automatic do_reset(input logic s, input logic r);
		@(posedge clk) #1 rst_n = 0;
		wake = 0;
		sel = s;
		rt_low = ~r;
		pinsel = 0;
		use_sec = 0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1;
		repeat (8) @(posedge clk);
		#1 wake = 1;
		repeat (12) @(posedge clk);
		#1 rt_low = 0;                                  // release after wakeup
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		jtag_probe_inst.scan({1'b1, a, d}, so);
		repeat (10) @(posedge clk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		jtag_probe_inst.scan({1'b0, a, 32'h00000000}, so);
		jtag_probe_inst.scan(38'h0000000000, so);
		d = so[31:0];
	endtask
	// primary mode: map widths, unmapped place, control outputs
	task automatic t_primary();
		logic [31:0] v;
		do_reset(1, 1);
		pinsel = 1;
		chk("trace", 32'h1, trace);
		chk("pinmux", 32'h0, pmux);
		chk("sec", 32'h0, sec);
		chk("returned_test_clock drive", 32'h2, {rt_oe, rt_out});
		jtag_probe_inst.tap_reset();
		wr(dbg_pkg::ADDR_DEBUG_CONTROL, 32'h00000005);
		chk("force", 32'h1, frc);
		chk("irq", 32'h1, irq);
		rd(dbg_pkg::ADDR_DEBUG_STATUS, v);
		chk("status", 32'h0000001D, v);
		wr(dbg_pkg::ADDR_M1_CTRL_VALUE, 32'hFFFFFFFF);
		rd(dbg_pkg::ADDR_M1_CTRL_VALUE, v);
		chk("ctrl value", 32'h000001FF, v);
		wr(5'h02, 32'hFFFFFFFF);
		rd(5'h02, v);
		chk("unmapped", 32'h00000000, v);
		wr(dbg_pkg::ADDR_COMMS_DATA, 32'hA5A55A5A);
		rd(dbg_pkg::ADDR_COMMS_DATA, v);
		chk("comms", 32'hA5A55A5A, v);
		$display("test primary done");
	endtask
	// non-primary modes: trace off, secondary jtag on software request
	task automatic t_second();
		logic [31:0] v;
		do_reset(0, 1);
		chk("normal trace", 32'h0, trace);
		do_reset(1, 0);
		chk("pinmux", 32'h1, pmux);
		chk("sec idle", 32'h0, sec);
		pinsel = 1;
		use_sec = 1;
		sel = 0;                                        // late select change must not count
		#1 chk("sec on", 32'h1, sec);
		chk("trace off", 32'h0, trace);
		jtag_probe_inst.tap_reset();
		wr(dbg_pkg::ADDR_DEBUG_CONTROL, 32'h00000004);
		chk("force", 32'h0, frc);
		chk("irq", 32'h1, irq);
		rd(dbg_pkg::ADDR_DEBUG_STATUS, v);
		chk("status", 32'h0000000A, v);
		$display("test secondary done");
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		t_primary();
		t_second();
		wrap_up();
	end
	initial begin
		#300000;
		n_fail++;
		wrap_up();
	end
endmodule // debug_port_select_logic_tb
